/* hw/lac_defines.svh */
`ifndef LAC_DEFINES_SVH
`define LAC_DEFINES_SVH

// register byte offsets
`define LAC_ADDR_CTRL      8'h00
`define LAC_ADDR_COOL      8'h04
`define LAC_ADDR_RUNCUR    8'h08
`define LAC_ADDR_LOWVEL    8'h0C
`define LAC_ADDR_HIGHVEL   8'h10
`define LAC_ADDR_THROFF    8'h14
`define LAC_ADDR_DRVSTAT   8'h18
`define LAC_ADDR_RAMPSTAT  8'h1C
`define LAC_ADDR_INTSTAT   8'h20
`define LAC_ADDR_INTMASK   8'h24

// widths
`define LAC_LOAD_W         10
`define LAC_CS_W           5
`define LAC_VEL_W          20
`define LAC_THROFF_W       7
`define LAC_INT_W          3

// control word bits
`define LAC_CTRL_STOP      0
`define LAC_CTRL_FILT      1
`define LAC_CTRL_EXTSD     2

// adaptation word fields
`define LAC_COOL_LOW_LO    0
`define LAC_COOL_WIN_LO    4
`define LAC_COOL_UP_LO     8
`define LAC_COOL_DN_LO     10
`define LAC_COOL_MINSEL    12
`define LAC_COOL_W         13

// driver status fields
`define LAC_DRV_LOAD_LO    0
`define LAC_DRV_CS_LO      16
`define LAC_DRV_STALL      24
`define LAC_DRV_ACTIVE     25

// ramp status and interrupt bits
`define LAC_RAMP_EVENT     0
`define LAC_RAMP_HALT      1
`define LAC_INT_STALL      0
`define LAC_INT_UP         1
`define LAC_INT_READING    2

// reset values
`define LAC_RST_RUNCUR     5'h1F
`define LAC_RST_VEL        20'h00000

// axi responses
`define LAC_RESP_OKAY      2'h0
`define LAC_RESP_SLVERR    2'h2

`endif

/* hw/lac_pkg.sv */
`include "lac_defines.svh"

package lac_pkg;

	typedef enum logic [2:0] {
		LAC_RUN     = 3'h1,
		LAC_STOPPED = 3'h2,
		LAC_WAITZ   = 3'h4
	} lac_stall_t;

	typedef struct packed {
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic [2:0]                   ctrl;
		logic [`LAC_COOL_W-1:0]       cool;
		logic [`LAC_CS_W-1:0]         runCur;
		logic [`LAC_VEL_W-1:0]        lowVel;
		logic [`LAC_VEL_W-1:0]        highVel;
		logic [`LAC_THROFF_W-1:0]     thrOffset;
		logic [`LAC_INT_W-1:0]        intMask;
		logic [`LAC_INT_W-1:0]        intStat;
		logic [`LAC_LOAD_W-1:0]       load;
		logic                         loadValid;
		logic [`LAC_LOAD_W+1:0]       filtAcc;
		logic [1:0]                   filtCnt;
		logic [`LAC_CS_W-1:0]         cs;
		logic [`LAC_CS_W:0]           downCnt;
		lac_stall_t                   state;
		logic                         stallEvent;
		logic                         stallFlag;
		logic                         paramsChg;
		logic                         halt;
		logic                         fsSwitch;
		logic                         irq;
	} lac_state_t;

endpackage : lac_pkg

/* hw/load_adaptive_current_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lac_defines.svh"

// How it works
// (R1) unfiltered: a fresh load reading is taken on every fullstep
// (R2) filter on: each reported reading is the mean of four measurements
// (R3) filter on: only one result every four fullsteps
// (R4) load threshold offset is signed, sign-extended on readback
// (R5) a reading of zero counts as a stall
// (R6) stall with stop enabled halts the ramp, velocity forced to zero
// (R7) stall stop also sets the stall flag in driver status
// (R8) write-back clears the event; restart after zero wait if parameters unchanged
// (R9) host should keep filtering off for stall detection
// (R10) below lower velocity threshold adaptation and stall stop are off; in external step mode the code ignores this threshold and keeps both on
// (R11) above upper velocity threshold both are off; also selects fullstepping
// (R12) low limit is lower field times 32; zero disables adaptation
// (R13) thresholds compare against the 10-bit load reading
// (R14) upper limit is (lower+window+1)*32; readings at or above decrease current
// (R15) each reading below low limit adds 1, 2, 4 or 8 to the scale
// (R16) decrement by one after 32, 8, 2 or 1 readings above upper limit
// (R17) floor is half of run current, or a quarter with select set
// (R18) actual current scale is readable status
// (R19) scale saturates at run current and at the floor
module load_adaptive_current_control (
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [`LAC_LOAD_W-1:0]    loadRaw,
	input  wire logic                      loadRawValid,
	input  wire logic [`LAC_VEL_W-1:0]     stepInterval,
	input  wire logic                      zeroWaitExpired,
	input  wire logic                      motionParamsChanged,
	output logic                           rampHalt,
	output logic [`LAC_CS_W-1:0]           actualCurrentScale,
	output logic [`LAC_THROFF_W-1:0]       loadThresholdOffset,
	output logic                           fullstepSwitch,
	output logic                           irq
);

	lac_pkg::lac_state_t q;
	lac_pkg::lac_state_t d;

	function automatic logic [31:0] lacMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : lacMerge

	function automatic logic [5:0] lacUpStep(input logic [1:0] sel);
		return 6'h01 << sel;
	endfunction : lacUpStep

	function automatic logic [`LAC_CS_W:0] lacDownCount(input logic [1:0] sel);
		logic [`LAC_CS_W:0] n;
		unique case (sel)
			2'h0: n = 6'h20;
			2'h1: n = 6'h08;
			2'h2: n = 6'h02;
			2'h3: n = 6'h01;
		endcase
		return n;
	endfunction : lacDownCount

	logic [3:0]               lowerThr;
	logic [3:0]               upperWin;
	logic [1:0]               upSel;
	logic [1:0]               dnSel;
	logic                     minSel;
	logic [`LAC_LOAD_W:0]     lowLimit;
	logic [`LAC_LOAD_W:0]     highLimit;
	logic [`LAC_CS_W-1:0]     floorCs;
	logic                     lowOk;
	logic                     highOk;
	logic                     windowOk;
	logic                     adaptActive;
	logic                     belowLow;
	logic                     aboveHigh;
	logic                     stallHit;
	logic [`LAC_LOAD_W+1:0]   filtSum;

	assign lowerThr  = q.cool[`LAC_COOL_LOW_LO +: 4];
	assign upperWin  = q.cool[`LAC_COOL_WIN_LO +: 4];
	assign upSel     = q.cool[`LAC_COOL_UP_LO +: 2];
	assign dnSel     = q.cool[`LAC_COOL_DN_LO +: 2];
	assign minSel    = q.cool[`LAC_COOL_MINSEL];
	assign lowLimit  = {2'h0, lowerThr, 5'h00}; // R12 R13
	assign highLimit = {1'b0, ({1'b0, lowerThr} + {1'b0, upperWin} + 5'h01),
		5'h00}; // R14
	// floor follows run current, so lowering run current drags the floor too
	assign floorCs   = minSel ? (q.runCur >> 2) : (q.runCur >> 1); // R17
	// step interval grows as velocity falls
	assign lowOk     = q.ctrl[`LAC_CTRL_EXTSD] || (stepInterval <= q.lowVel); // R10
	assign highOk    = stepInterval >= q.highVel; // R11
	assign windowOk  = lowOk && highOk;
	assign adaptActive = windowOk && (lowerThr != 4'h0); // R12
	assign belowLow  = {1'b0, q.load} < lowLimit; // R12
	assign aboveHigh = {1'b0, q.load} >= highLimit; // R14
	assign stallHit  = q.loadValid && (q.load == 10'h000) && windowOk
		&& q.ctrl[`LAC_CTRL_STOP]; // R5
	assign filtSum   = q.filtAcc + {2'h0, loadRaw};

	always_comb begin
		logic [`LAC_INT_W-1:0] intSet;
		logic                  intRdClr;
		logic [5:0]            upSum;
		logic [31:0]           wv;
		logic                  wrEvtClr;
		intSet   = '0;
		intRdClr = 1'b0;
		upSum    = '0;
		wv       = '0;
		wrEvtClr = 1'b0;
		d = q;
		d.awready   = 1'b0;
		d.wready    = 1'b0;
		d.arready   = 1'b0;
		d.loadValid = 1'b0;

		// load reading path
		if (loadRawValid) begin
			if (!q.ctrl[`LAC_CTRL_FILT]) begin
				d.load      = loadRaw; // R1
				d.loadValid = 1'b1;
				d.filtAcc   = '0;
				d.filtCnt   = 2'h0;
			end else begin
				d.filtCnt = q.filtCnt + 2'h1;
				if (q.filtCnt == 2'h3) begin
					d.load      = filtSum[`LAC_LOAD_W+1:2]; // R2
					d.loadValid = 1'b1; // R3
					d.filtAcc   = '0;
				end else begin
					d.filtAcc = filtSum;
				end
			end
		end
		if (d.loadValid) begin
			intSet[`LAC_INT_READING] = 1'b1;
		end

		// current scale adaptation
		if (!adaptActive) begin
			d.cs      = q.runCur; // R12
			d.downCnt = '0;
		end else if (q.cs > q.runCur) begin
			d.cs = q.runCur; // R19
		end else if (q.loadValid) begin
			if (belowLow) begin
				upSum = {1'b0, q.cs} + lacUpStep(upSel); // R15
				d.cs  = (upSum > {1'b0, q.runCur}) ? q.runCur : upSum[`LAC_CS_W-1:0]; // R19
				d.downCnt = '0;
				intSet[`LAC_INT_UP] = 1'b1;
			end else if (aboveHigh) begin
				if (q.downCnt + 6'h01 >= lacDownCount(dnSel)) begin
					d.cs = (q.cs > floorCs) ? q.cs - 5'h01 : floorCs; // R16 R19
					d.downCnt = '0;
				end else begin
					d.downCnt = q.downCnt + 6'h01; // R16
				end
			end
		end else if (q.cs < floorCs) begin
			d.cs = floorCs; // R19
		end

		// write channel
		if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
			d.awready = 1'b1;
			d.wready  = 1'b1;
			d.bvalid  = 1'b1;
			d.bresp   = `LAC_RESP_OKAY;
			unique case (s_axi_awaddr)
				`LAC_ADDR_CTRL: begin
					wv = lacMerge({29'h0, q.ctrl}, s_axi_wdata, s_axi_wstrb);
					d.ctrl = wv[2:0];
				end
				`LAC_ADDR_COOL: begin
					wv = lacMerge({19'h0, q.cool}, s_axi_wdata, s_axi_wstrb);
					d.cool = wv[`LAC_COOL_W-1:0];
				end
				`LAC_ADDR_RUNCUR: begin
					wv = lacMerge({27'h0, q.runCur}, s_axi_wdata, s_axi_wstrb);
					d.runCur = wv[`LAC_CS_W-1:0];
				end
				`LAC_ADDR_LOWVEL: begin
					wv = lacMerge({12'h0, q.lowVel}, s_axi_wdata, s_axi_wstrb);
					d.lowVel = wv[`LAC_VEL_W-1:0];
				end
				`LAC_ADDR_HIGHVEL: begin
					wv = lacMerge({12'h0, q.highVel}, s_axi_wdata, s_axi_wstrb);
					d.highVel = wv[`LAC_VEL_W-1:0];
				end
				`LAC_ADDR_THROFF: begin
					wv = lacMerge({25'h0, q.thrOffset}, s_axi_wdata, s_axi_wstrb);
					d.thrOffset = wv[`LAC_THROFF_W-1:0];
				end
				`LAC_ADDR_RAMPSTAT: begin
					// write-back of a read value clears a pending event
					wrEvtClr = s_axi_wstrb[0] && s_axi_wdata[`LAC_RAMP_EVENT]; // R8
				end
				`LAC_ADDR_INTMASK: begin
					wv = lacMerge({29'h0, q.intMask}, s_axi_wdata, s_axi_wstrb);
					d.intMask = wv[`LAC_INT_W-1:0];
				end
				`LAC_ADDR_DRVSTAT, `LAC_ADDR_INTSTAT: begin
					d.bresp = `LAC_RESP_OKAY;
				end
				default: d.bresp = `LAC_RESP_SLVERR;
			endcase
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// read channel
		if (s_axi_arvalid && !q.arready && !q.rvalid) begin
			d.arready = 1'b1;
			d.rvalid  = 1'b1;
			d.rresp   = `LAC_RESP_OKAY;
			d.rdata   = 32'h0000_0000;
			unique case (s_axi_araddr)
				`LAC_ADDR_CTRL:    d.rdata = {29'h0, q.ctrl};
				`LAC_ADDR_COOL:    d.rdata = {19'h0, q.cool};
				`LAC_ADDR_RUNCUR:  d.rdata = {27'h0, q.runCur};
				`LAC_ADDR_LOWVEL:  d.rdata = {12'h0, q.lowVel};
				`LAC_ADDR_HIGHVEL: d.rdata = {12'h0, q.highVel};
				`LAC_ADDR_THROFF:  d.rdata = {{25{q.thrOffset[`LAC_THROFF_W-1]}}, q.thrOffset}; // R4
				`LAC_ADDR_DRVSTAT: begin
					d.rdata[`LAC_DRV_LOAD_LO +: `LAC_LOAD_W] = q.load;
					d.rdata[`LAC_DRV_CS_LO +: `LAC_CS_W]     = q.cs; // R18
					d.rdata[`LAC_DRV_STALL]                  = q.stallFlag; // R7
					d.rdata[`LAC_DRV_ACTIVE]                 = adaptActive;
				end
				`LAC_ADDR_RAMPSTAT: begin
					d.rdata[`LAC_RAMP_EVENT] = q.stallEvent;
					d.rdata[`LAC_RAMP_HALT]  = q.halt;
				end
				`LAC_ADDR_INTSTAT: begin
					d.rdata  = {29'h0, q.intStat};
					intRdClr = 1'b1;
				end
				`LAC_ADDR_INTMASK: d.rdata = {29'h0, q.intMask};
				default:           d.rresp = `LAC_RESP_SLVERR;
			endcase
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// stall stop sequencing
		unique case (q.state)
			lac_pkg::LAC_RUN: begin
				if (stallHit) begin
					d.state      = lac_pkg::LAC_STOPPED; // R6
					d.stallEvent = 1'b1;
					d.stallFlag  = 1'b1; // R7
					d.paramsChg  = 1'b0;
					intSet[`LAC_INT_STALL] = 1'b1;
				end
			end
			lac_pkg::LAC_STOPPED: begin
				if (!q.ctrl[`LAC_CTRL_STOP]) begin
					d.state = lac_pkg::LAC_RUN;
				end else if (wrEvtClr) begin
					// new motion parameters take over at once, old ones wait out the zero time
					d.state = q.paramsChg ? lac_pkg::LAC_RUN : lac_pkg::LAC_WAITZ; // R8
				end
			end
			lac_pkg::LAC_WAITZ: begin
				if (zeroWaitExpired || !q.ctrl[`LAC_CTRL_STOP] || motionParamsChanged) begin
					d.state = lac_pkg::LAC_RUN; // R8
				end
			end
			default: d.state = lac_pkg::LAC_RUN;
		endcase
		if (motionParamsChanged && q.state != lac_pkg::LAC_RUN) begin
			d.paramsChg = 1'b1;
		end
		if (d.state == lac_pkg::LAC_RUN) begin
			d.stallEvent = 1'b0;
			d.stallFlag  = 1'b0;
		end
		d.halt     = d.state != lac_pkg::LAC_RUN; // R6
		d.fsSwitch = !highOk; // R11

		// set wins over read clear
		d.intStat = (intRdClr ? '0 : q.intStat) | intSet;
		d.irq     = |(d.intStat & d.intMask);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q         <= '0;
			q.runCur  <= `LAC_RST_RUNCUR;
			q.cs      <= `LAC_RST_RUNCUR;
			q.lowVel  <= `LAC_RST_VEL;
			q.highVel <= `LAC_RST_VEL;
			q.state   <= lac_pkg::LAC_RUN;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready       = q.awready;
	assign s_axi_wready        = q.wready;
	assign s_axi_bvalid        = q.bvalid;
	assign s_axi_bresp         = q.bresp;
	assign s_axi_arready       = q.arready;
	assign s_axi_rvalid        = q.rvalid;
	assign s_axi_rdata         = q.rdata;
	assign s_axi_rresp         = q.rresp;
	assign rampHalt            = q.halt;
	assign actualCurrentScale  = q.cs;
	assign loadThresholdOffset = q.thrOffset;
	assign fullstepSwitch      = q.fsSwitch;
	assign irq                 = q.irq;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence stallSeen_s;
		(q.state == lac_pkg::LAC_RUN) && stallHit;
	endsequence

	sequence waitDone_s;
		(q.state == lac_pkg::LAC_WAITZ) && zeroWaitExpired;
	endsequence

	ramp_halt_a: assert property (stallSeen_s |=> rampHalt [*2]) // R6
		else $error("ramp not halted after stall");
	stall_flag_a: assert property (stallSeen_s |=> q.stallFlag && q.stallEvent) // R7
		else $error("stall flag not set on stall stop");
	restart_wait_a: assert property (waitDone_s |=> !rampHalt && !q.stallFlag) // R8
		else $error("no restart after zero wait");
	halt_hold_a: assert property ((q.state == lac_pkg::LAC_STOPPED) && q.ctrl[`LAC_CTRL_STOP]
		&& !(s_axi_awvalid && s_axi_wvalid) |=> rampHalt) // R8
		else $error("halt released without clear");
	unfilt_update_a: assert property (loadRawValid && !q.ctrl[`LAC_CTRL_FILT]
		|=> q.loadValid && q.load == $past(loadRaw)) // R1
		else $error("unfiltered reading not taken");
	filt_rate_a: assert property (loadRawValid && q.ctrl[`LAC_CTRL_FILT] && q.filtCnt != 2'h3
		|=> !q.loadValid) // R3
		else $error("filtered result too early");
	filt_mean_a: assert property (loadRawValid && q.ctrl[`LAC_CTRL_FILT] && q.filtCnt == 2'h3
		|=> q.loadValid && q.load == $past(filtSum[`LAC_LOAD_W+1:2])) // R2
		else $error("filtered result wrong");
	low_vel_a: assert property (!q.ctrl[`LAC_CTRL_EXTSD] && stepInterval > q.lowVel
		|-> !adaptActive && !stallHit) // R10
		else $error("active below lower velocity");
	high_vel_a: assert property (stepInterval < q.highVel |-> !windowOk ##1 fullstepSwitch) // R11
		else $error("active above upper velocity");
	adapt_off_a: assert property (lowerThr == 4'h0 ##1 lowerThr == 4'h0
		|-> actualCurrentScale == $past(q.runCur)) // R12
		else $error("scale not at run current when disabled");
	scale_up_a: assert property (q.loadValid && adaptActive && belowLow && q.cs <= q.runCur
		|=> actualCurrentScale >= $past(q.cs) && actualCurrentScale <= $past(q.runCur)) // R15
		else $error("scale increment wrong");
	scale_dn_a: assert property (q.loadValid && adaptActive && aboveHigh && q.cs > floorCs
		&& q.cs <= q.runCur && dnSel == 2'h3 |=> actualCurrentScale == $past(q.cs) - 5'h01) // R16
		else $error("scale decrement wrong");

endmodule : load_adaptive_current_control

`default_nettype wire

/* tb/lac_motor_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lac_defines.svh"

module lac_motor_model #(
	parameter int ZERO_WAIT = 20
) (
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   stepReq,
	input  wire logic [`LAC_LOAD_W-1:0] stepLoad,
	input  wire logic                   rampHalt,
	output logic [`LAC_LOAD_W-1:0]      loadRaw,
	output logic                        loadRawValid,
	output logic                        zeroWaitExpired
);
	int waitCnt;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			loadRaw <= '0;
			loadRawValid <= 1'b0;
			zeroWaitExpired <= 1'b0;
			waitCnt <= 0;
		end else begin
			loadRawValid <= stepReq;
			// outside a pulse the value is not held, so stale data cannot pass
			loadRaw <= stepReq ? stepLoad : ~loadRaw;
			// zero wait keeps expiring while the ramp stands still
			zeroWaitExpired <= rampHalt && (waitCnt == ZERO_WAIT - 1);
			waitCnt <= (!rampHalt || waitCnt == ZERO_WAIT - 1) ? 0 : waitCnt + 1;
		end
	end
endmodule : lac_motor_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lac_defines.svh"

module testbench;
	localparam int ZW = 20;
	localparam logic [7:0] RA [7] = '{`LAC_ADDR_CTRL, `LAC_ADDR_COOL, `LAC_ADDR_RUNCUR,
		`LAC_ADDR_LOWVEL, `LAC_ADDR_HIGHVEL, `LAC_ADDR_THROFF, `LAC_ADDR_INTMASK};
	localparam logic [31:0] RV [7] = '{0, 0, 32'h1F, 0, 0, 0, 0};
	logic                    sys_clk, sys_rst, stepReq, motionParamsChanged;
	logic                    s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]              s_axi_awaddr, s_axi_araddr;
	logic [31:0]             s_axi_wdata, rd;
	logic [3:0]              s_axi_wstrb;
	logic [1:0]              resp;
	logic [`LAC_LOAD_W-1:0]  stepLoad;
	logic [`LAC_VEL_W-1:0]   stepInterval;
	wire logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]         s_axi_bresp, s_axi_rresp;
	wire logic [31:0]        s_axi_rdata;
	wire logic [`LAC_LOAD_W-1:0] loadRaw;
	wire logic               loadRawValid, zeroWaitExpired, rampHalt, fullstepSwitch, irq;
	wire logic [`LAC_CS_W-1:0] actualCurrentScale;
	wire logic [`LAC_THROFF_W-1:0] loadThresholdOffset;
	int                      n_mismatch, cmp_count, expCs, dnCnt, upCode, dnCode, minSel, sum;

	load_adaptive_current_control load_adaptive_current_control_inst (.sys_clk, .sys_rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .loadRaw, .loadRawValid, .stepInterval,
		.zeroWaitExpired, .motionParamsChanged, .rampHalt, .actualCurrentScale,
		.loadThresholdOffset, .fullstepSwitch, .irq);
	lac_motor_model #(.ZERO_WAIT(ZW)) lac_motor_model_inst (.sys_clk, .sys_rst, .stepReq,
		.stepLoad, .rampHalt, .loadRaw, .loadRawValid, .zeroWaitExpired);

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		// idle edge first: a release and the next request never share a time step
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : axi_rd

	task automatic fullstep(input logic [`LAC_LOAD_W-1:0] v);
		stepReq <= 1'b1;
		stepLoad <= v;
		@(posedge sys_clk);
		stepReq <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : fullstep

	// expected scale for lower field 2 (limit 64) and window 1 (limit 128)
	function automatic void mdl(input int v);
		int n;
		n = (dnCode == 0) ? 32 : (dnCode == 1) ? 8 : (dnCode == 2) ? 2 : 1;
		if (v < 64) begin
			expCs = (expCs + (1 << upCode) > 31) ? 31 : expCs + (1 << upCode);
			dnCnt = 0;
		end else if (v >= 128) begin
			dnCnt++;
			if (dnCnt == n) begin
				dnCnt = 0;
				if (expCs > (31 >> (minSel + 1))) expCs--;
			end
		end
	endfunction : mdl

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		int i, k, v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		{stepReq, motionParamsChanged, stepLoad} <= '0;
		s_axi_wstrb <= 4'hF;
		stepInterval <= 20'h00064;
		sys_rst <= 1'b1;
		void'($urandom(23));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		chk(actualCurrentScale, 32'h1F);
		for (i = 0; i < 7; i++) begin
			axi_rd(RA[i]);
			chk(rd, RV[i]);
		end
		axi_rd(8'h28);
		chk(rd, 32'h0);
		chk(resp, `LAC_RESP_SLVERR);
		axi_wr(8'h28, 32'h1);
		chk(resp, `LAC_RESP_SLVERR);
		$display("test reset done, mismatches %0d", n_mismatch);

		axi_wr(`LAC_ADDR_LOWVEL, 32'hFFFFF);
		axi_wr(`LAC_ADDR_INTMASK, 32'h1);
		expCs = 31;
		for (i = 0; i < 4; i++) begin
			upCode = i;
			dnCode = i;
			minSel = (i == 3);
			axi_wr(`LAC_ADDR_COOL, (minSel << 12) | (dnCode << 10) | (upCode << 8) | 32'h12);
			for (k = 0; k < 40; k++) begin
				// first reading low so the down count starts from zero
				case (k == 0 ? 0 : $urandom % 6)
					0: v = 63;
					1: v = 64;
					2: v = 128;
					4: v = 1 + $urandom % 63;
					default: v = 128 + $urandom % 896;
				endcase
				fullstep(v[9:0]);
				mdl(v);
				chk(actualCurrentScale, expCs);
			end
		end
		axi_rd(`LAC_ADDR_DRVSTAT);
		chk(rd[20:16], expCs);
		chk(irq, 1'b0);
		$display("test adaptation done, mismatches %0d", n_mismatch);

		axi_wr(`LAC_ADDR_CTRL, 32'h1);
		axi_wr(`LAC_ADDR_LOWVEL, 32'hC8);
		stepInterval <= 20'h0012C;
		fullstep(0);
		chk(rampHalt, 1'b0);
		stepInterval <= 20'h00064;
		axi_wr(`LAC_ADDR_HIGHVEL, 32'h1F4);
		fullstep(0);
		chk({fullstepSwitch, rampHalt}, 2'h2);
		axi_wr(`LAC_ADDR_HIGHVEL, 32'h32);
		repeat (2) @(posedge sys_clk);
		chk(fullstepSwitch, 1'b0);
		fullstep(0);
		chk({rampHalt, irq}, 2'h3);
		axi_rd(`LAC_ADDR_DRVSTAT);
		chk(rd[24], 1'b1);
		axi_rd(`LAC_ADDR_INTSTAT);
		chk(rd[0], 1'b1);
		axi_rd(`LAC_ADDR_INTSTAT);
		chk({rd[0], irq}, 2'h0);
		// zero wait expires several times, yet no restart without the clear
		repeat (3 * ZW) @(posedge sys_clk);
		chk(rampHalt, 1'b1);
		axi_rd(`LAC_ADDR_RAMPSTAT);
		chk(rd[1:0], 2'h3);
		axi_wr(`LAC_ADDR_RAMPSTAT, rd);
		k = 0;
		while (rampHalt && k < ZW + 8) begin
			@(posedge sys_clk);
			k++;
		end
		chk(rampHalt, 1'b0);
		// second stall: new motion parameters, so the write-back releases at once
		fullstep(0);
		chk(rampHalt, 1'b1);
		motionParamsChanged <= 1'b1;
		@(posedge sys_clk);
		motionParamsChanged <= 1'b0;
		axi_wr(`LAC_ADDR_RAMPSTAT, 32'h1);
		chk(rampHalt, 1'b0);
		axi_rd(`LAC_ADDR_DRVSTAT);
		chk(rd[24], 1'b0);
		// external step mode ignores the lower velocity threshold
		axi_wr(`LAC_ADDR_CTRL, 32'h5);
		stepInterval <= 20'h0012C;
		fullstep(0);
		chk(rampHalt, 1'b1);
		axi_wr(`LAC_ADDR_CTRL, 32'h4);
		repeat (2) @(posedge sys_clk);
		chk(rampHalt, 1'b0);
		stepInterval <= 20'h00064;
		$display("test stall done, mismatches %0d", n_mismatch);

		axi_wr(`LAC_ADDR_CTRL, 32'h0);
		v = $urandom % 1024;
		fullstep(v[9:0]);
		axi_rd(`LAC_ADDR_DRVSTAT);
		chk(rd[9:0], v[9:0]);
		axi_wr(`LAC_ADDR_CTRL, 32'h2);
		sum = 0;
		for (i = 0; i < 4; i++) begin
			k = $urandom % 1024;
			sum += k;
			fullstep(k[9:0]);
			axi_rd(`LAC_ADDR_DRVSTAT);
			chk(rd[9:0], (i == 3) ? sum >> 2 : v);
		end
		$display("test filter done, mismatches %0d", n_mismatch);

		for (i = 0; i < 2; i++) begin
			v = i ? 32'h40 : 32'h3F;
			axi_wr(`LAC_ADDR_THROFF, v);
			repeat (2) @(posedge sys_clk);
			chk(loadThresholdOffset, v);
			axi_rd(`LAC_ADDR_THROFF);
			chk(rd, i ? 32'hFFFFFFC0 : 32'h3F);
		end
		axi_wr(`LAC_ADDR_CTRL, 32'h0);
		axi_wr(`LAC_ADDR_RUNCUR, 32'h14);
		axi_wr(`LAC_ADDR_COOL, 32'h0);
		fullstep(1);
		chk(actualCurrentScale, 32'h14);
		$display("test offset and disable done, mismatches %0d", n_mismatch);
		final_report();
	end
endmodule : testbench
`default_nettype wire
